// ==== verilog/peil_top.sv ====
// PLL event interrupt logic with classic Wishbone register slave
`timescale 1ns/1ps
`default_nettype none
`include "peil_map.svh"

module peil_top
   import peil_pkg::*;
#(
   parameter int unsigned ADDR_W = 8
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire peil_src_type src_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic irq_o
);

   peil_regs_type st_reg;
   peil_regs_type st_next;

   peil_src_type src_q;
   logic [7:0] live;
   logic [7:0] edge_hit;
   logic [7:0] edge_set;
   logic [7:0] clr_mask;
   logic [7:0] unblocked;
   logic [31:0] rd_mux;
   logic req;
   logic wr;
   logic wr_flag;
   logic hit_or;
   logic hit_and;

   function automatic logic reg_hit(input logic [ADDR_W-1:0] adr, input logic [5:0] idx);
      reg_hit = (adr[7:2] == idx) && (adr[1:0] == 2'h0);
   endfunction

   // input loss wins over lock loss
   always_comb
   begin
      src_q = src_i;
      src_q.pll1_lock_lost = src_i.pll1_lock_lost && !src_i.pll1_input_lost;
      src_q.pll2_lock_lost = src_i.pll2_lock_lost && !src_i.pll2_input_lost;
   end

   peil_edge_detect #(
      .SRC_W(8)
   ) u_edge (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .src_i(src_q),
      .pol_i(st_reg.edge_sel),
      .live_o(live),
      .edge_o(edge_hit)
   );

   assign req = wb_cyc_i && wb_stb_i;
   // Write lands on the edge where the master sees ack, as classic Wishbone expects
   assign wr = req && wb_we_i && st_reg.ack && wb_sel_i[0];
   assign wr_flag = wr && reg_hit(wb_adr_i, `PEIL_FLAG_IDX);

   assign edge_set = st_reg.en ? edge_hit : 8'h00;

   // zero bits of a flag write clear
   assign clr_mask = wr_flag ? ~wb_dat_i[7:0] : 8'h00;

   assign unblocked = ~st_reg.block;
   assign hit_or = |(st_reg.event_latch & unblocked);
   // An all-blocked AND set would otherwise fire for nothing, so it needs one open source
   assign hit_and = (&(st_reg.event_latch | st_reg.block)) && (|unblocked);

   // Unmapped offsets answer with zero data
   always_comb
   begin
      rd_mux = 32'h0000_0000;
      if (reg_hit(wb_adr_i, `PEIL_LIVE_IDX))
      begin
         rd_mux[7:0] = live;
      end
      else if (reg_hit(wb_adr_i, `PEIL_MASK_IDX))
      begin
         rd_mux[7:0] = st_reg.block;
      end
      else if (reg_hit(wb_adr_i, `PEIL_POL_IDX))
      begin
         rd_mux[7:0] = st_reg.edge_sel;
      end
      else if (reg_hit(wb_adr_i, `PEIL_FLAG_IDX))
      begin
         rd_mux[7:0] = st_reg.event_latch;
      end
      else if (reg_hit(wb_adr_i, `PEIL_CTL_IDX))
      begin
         rd_mux[`PEIL_CTL_EN_BIT] = st_reg.en;
         rd_mux[`PEIL_CTL_AND_OR_BIT] = st_reg.and_or;
      end
      else
      begin
         rd_mux = 32'h0000_0000;
      end
   end

   always_comb
   begin
      st_next = st_reg;
      st_next.ack = req && !st_reg.ack;
      st_next.rdata = (req && !st_reg.ack) ? rd_mux : 32'h0000_0000;
      if (wr && reg_hit(wb_adr_i, `PEIL_MASK_IDX))
      begin
         st_next.block = wb_dat_i[7:0];
      end
      if (wr && reg_hit(wb_adr_i, `PEIL_POL_IDX))
      begin
         st_next.edge_sel = wb_dat_i[7:0];
      end
      if (wr && reg_hit(wb_adr_i, `PEIL_CTL_IDX))
      begin
         st_next.en = wb_dat_i[`PEIL_CTL_EN_BIT];
         st_next.and_or = wb_dat_i[`PEIL_CTL_AND_OR_BIT];
      end
      st_next.event_latch = edge_set | (st_reg.event_latch & ~clr_mask);
      st_next.irq = st_reg.en && (st_reg.and_or ? hit_and : hit_or);
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st_reg.block <= `PEIL_MASK_RST;
         st_reg.edge_sel <= `PEIL_POL_RST;
         st_reg.event_latch <= `PEIL_FLAG_RST;
         st_reg.en <= 1'b0;
         st_reg.and_or <= 1'b0;
         st_reg.ack <= 1'b0;
         st_reg.rdata <= 32'h0000_0000;
         st_reg.irq <= 1'b0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign wb_dat_o = st_reg.rdata;
   assign wb_ack_o = st_reg.ack;
   assign irq_o = st_reg.irq;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   property p_block_silences;
      (st_reg.en && !st_reg.and_or && ((st_reg.event_latch & ~st_reg.block) == 8'h00))
         |=> !irq_o;
   endproperty
   a_block_silences: assert property (p_block_silences)
      else $error("blocked flags raised the interrupt");

   property p_or_fires;
      (st_reg.en && !st_reg.and_or && ((st_reg.event_latch & ~st_reg.block) != 8'h00))
         |=> irq_o;
   endproperty
   a_or_fires: assert property (p_or_fires)
      else $error("unblocked flag did not raise interrupt in OR mode");

   property p_and_needs_all;
      (st_reg.en && st_reg.and_or && ((st_reg.event_latch | st_reg.block) != 8'hff))
         |=> !irq_o;
   endproperty
   a_and_needs_all: assert property (p_and_needs_all)
      else $error("AND mode fired with an unblocked flag clear");

   property p_edge_latches;
      (st_reg.en && (edge_hit != 8'h00)) |=> ((st_reg.event_latch & $past(edge_hit)) == $past(edge_hit));
   endproperty
   a_edge_latches: assert property (p_edge_latches)
      else $error("qualifying edge did not set its flag");

   property p_no_spurious_set;
      1'b1 |=> ((st_reg.event_latch & ~$past(st_reg.event_latch) & ~$past(edge_set)) == 8'h00);
   endproperty
   a_no_spurious_set: assert property (p_no_spurious_set)
      else $error("flag set without a selected edge");

   property p_disabled_hold;
      (!st_reg.en && !wr_flag) |=> (st_reg.event_latch == $past(st_reg.event_latch));
   endproperty
   a_disabled_hold: assert property (p_disabled_hold)
      else $error("flag changed while disabled");

   property p_disabled_quiet;
      !st_reg.en |=> !irq_o;
   endproperty
   a_disabled_quiet: assert property (p_disabled_quiet)
      else $error("interrupt raised while disabled");

   property p_zero_clears;
      wr_flag |=> ((st_reg.event_latch & ~$past(wb_dat_i[7:0]) & ~$past(edge_set)) == 8'h00);
   endproperty
   a_zero_clears: assert property (p_zero_clears)
      else $error("writing zero did not clear the flag");

   property p_one_keeps;
      wr_flag |=> ((st_reg.event_latch & $past(st_reg.event_latch) & $past(wb_dat_i[7:0]))
         == ($past(st_reg.event_latch) & $past(wb_dat_i[7:0])));
   endproperty
   a_one_keeps: assert property (p_one_keeps)
      else $error("writing one disturbed a set flag");

   property p_input_loss_wins;
      !(live[`PEIL_BIT_PLL1_LOCK_LOST] && live[`PEIL_BIT_PLL1_INPUT_LOST]) &&
      !(live[`PEIL_BIT_PLL2_LOCK_LOST] && live[`PEIL_BIT_PLL2_INPUT_LOST]);
   endproperty
   a_input_loss_wins: assert property (p_input_loss_wins)
      else $error("lock lost shown together with input lost");

   property p_reset_clear;
      $past(rst_i) |-> (st_reg.event_latch == 8'h00 && !irq_o);
   endproperty
   a_reset_clear: assert property (@(posedge clk_i) p_reset_clear)
      else $error("flags not clear after reset");

   property p_ack_single;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_single: assert property (p_ack_single)
      else $error("ack held for more than one cycle");

   property p_rise_only;
      1'b1 |-> ((edge_hit & st_reg.edge_sel & ~(live & ~$past(live))) == 8'h00);
   endproperty
   a_rise_only: assert property (p_rise_only)
      else $error("rising select reported an edge without a rise");

   property p_fall_only;
      1'b1 |-> ((edge_hit & ~st_reg.edge_sel & ~(~live & $past(live))) == 8'h00);
   endproperty
   a_fall_only: assert property (p_fall_only)
      else $error("falling select reported an edge without a fall");

   property p_block_write;
      (wr && reg_hit(wb_adr_i, `PEIL_MASK_IDX)) |=> (st_reg.block == $past(wb_dat_i[7:0]));
   endproperty
   a_block_write: assert property (p_block_write)
      else $error("block register did not take the written value");

   property p_edge_sel_write;
      (wr && reg_hit(wb_adr_i, `PEIL_POL_IDX)) |=> (st_reg.edge_sel == $past(wb_dat_i[7:0]));
   endproperty
   a_edge_sel_write: assert property (p_edge_sel_write)
      else $error("edge select register did not take the written value");

   property p_block_read;
      (req && !wb_ack_o && reg_hit(wb_adr_i, `PEIL_MASK_IDX)) |=>
         (wb_dat_o[7:0] == $past(st_reg.block));
   endproperty
   a_block_read: assert property (p_block_read)
      else $error("block register read back wrong");

   property p_edge_sel_read;
      (req && !wb_ack_o && reg_hit(wb_adr_i, `PEIL_POL_IDX)) |=>
         (wb_dat_o[7:0] == $past(st_reg.edge_sel));
   endproperty
   a_edge_sel_read: assert property (p_edge_sel_read)
      else $error("edge select register read back wrong");

   property p_latch_read;
      (req && !wb_ack_o && reg_hit(wb_adr_i, `PEIL_FLAG_IDX)) |=>
         (wb_dat_o[7:0] == $past(st_reg.event_latch));
   endproperty
   a_latch_read: assert property (p_latch_read)
      else $error("event latch read back wrong");

   property p_latch_sticky;
      !wr_flag |=> ((st_reg.event_latch & $past(st_reg.event_latch)) == $past(st_reg.event_latch));
   endproperty
   a_latch_sticky: assert property (p_latch_sticky)
      else $error("flag dropped without a clearing write");

   property p_and_fires;
      (st_reg.en && st_reg.and_or && ((st_reg.event_latch | st_reg.block) == 8'hff) &&
         (st_reg.block != 8'hff)) |=> irq_o;
   endproperty
   a_and_fires: assert property (p_and_fires)
      else $error("AND mode did not fire with all open flags set");

   property p_all_blocked_quiet;
      (st_reg.and_or && (st_reg.block == 8'hff)) |=> !irq_o;
   endproperty
   a_all_blocked_quiet: assert property (p_all_blocked_quiet)
      else $error("AND mode fired with every source blocked");

   property p_set_beats_clear;
      (wr_flag && (edge_set != 8'h00)) |=> ((st_reg.event_latch & $past(edge_set)) == $past(edge_set));
   endproperty
   a_set_beats_clear: assert property (p_set_beats_clear)
      else $error("clearing write lost an edge of the same cycle");

   // Every request is answered next cycle
   property p_ack_answers;
      (req && !wb_ack_o) |=> wb_ack_o;
   endproperty
   a_ack_answers: assert property (p_ack_answers)
      else $error("bus request not answered in one cycle");

   c_rise_seen: cover property ((edge_hit & st_reg.edge_sel) != 8'h00);
   c_or_irq: cover property (st_reg.en && !st_reg.and_or ##1 irq_o);
   c_and_irq: cover property (st_reg.en && st_reg.and_or ##1 irq_o);
   c_set_and_clear: cover property (wr_flag && (edge_set != 8'h00));
   c_flag_cleared: cover property (wr_flag && (st_reg.event_latch != 8'h00) ##1
      (st_reg.event_latch == 8'h00));

endmodule
`default_nettype wire

// ==== verilog/peil_map.svh ====
// Register indices, field positions, reset values and timing counts of the PLL event interrupt logic
`ifndef PEIL_MAP_SVH
`define PEIL_MAP_SVH

// Register word indices; byte address is four times the index
`define PEIL_LIVE_IDX 6'h0d
`define PEIL_MASK_IDX 6'h0e
`define PEIL_POL_IDX 6'h0f
`define PEIL_FLAG_IDX 6'h10
`define PEIL_CTL_IDX 6'h11

// Source bit positions, shared by live view, block, edge select and event latch
`define PEIL_BIT_PLL1_LOCK_LOST 7
`define PEIL_BIT_PLL1_INPUT_LOST 6
`define PEIL_BIT_PLL1_VCO_CAL 5
`define PEIL_BIT_PLL2_LOCK_LOST 4
`define PEIL_BIT_PLL2_INPUT_LOST 3
`define PEIL_BIT_PLL2_VCO_CAL 2
`define PEIL_BIT_PLL1_REF_RETURN 1
`define PEIL_BIT_PLL2_REF_RETURN 0

// Control register fields
`define PEIL_CTL_EN_BIT 0
`define PEIL_CTL_AND_OR_BIT 1

// Reset values
`define PEIL_MASK_RST 8'h00
`define PEIL_POL_RST 8'h00
`define PEIL_FLAG_RST 8'h00
`define PEIL_CTL_RST 2'h0

// Number of source samples between reset release and first edge
`define PEIL_SYNC_STAGES 2

`endif

// ==== verilog/peil_pkg.sv ====
// Types of the PLL event interrupt logic
`default_nettype none
package peil_pkg;

   typedef struct packed
   {
      logic pll1_lock_lost;
      logic pll1_input_lost;
      logic pll1_vco_cal_active;
      logic pll2_lock_lost;
      logic pll2_input_lost;
      logic pll2_vco_cal_active;
      logic pll1_ref_return_primary;
      logic pll2_ref_return_primary;
   } peil_src_type;

   typedef enum logic [2:0]
   {
      PEIL_FILL1 = 3'b001,
      PEIL_FILL2 = 3'b010,
      PEIL_RUN = 3'b100
   } peil_fill_type;

   typedef struct packed
   {
      logic [7:0] block;
      logic [7:0] edge_sel;
      logic [7:0] event_latch;
      logic en;
      logic and_or;
      logic ack;
      logic [31:0] rdata;
      logic irq;
   } peil_regs_type;

endpackage
`default_nettype wire

// ==== verilog/peil_edge_detect.sv ====
// Source synchroniser and selectable edge detector
`timescale 1ns/1ps
`default_nettype none
`include "peil_map.svh"

module peil_edge_detect
   import peil_pkg::*;
#(
   parameter int unsigned SRC_W = 8
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [SRC_W-1:0] src_i,
   input wire logic [SRC_W-1:0] pol_i,
   output logic [SRC_W-1:0] live_o,
   output logic [SRC_W-1:0] edge_o
);

   typedef struct packed
   {
      logic [SRC_W-1:0] meta;
      logic [SRC_W-1:0] sync;
      logic [SRC_W-1:0] prev;
      peil_fill_type phase;
      logic armed;
   } peil_edge_state_type;

   peil_edge_state_type st_reg;
   peil_edge_state_type st_next;

   always_comb
   begin
      st_next = st_reg;
      st_next.meta = src_i;
      st_next.sync = st_reg.meta;
      st_next.prev = st_reg.sync;
      // Prev only holds a post-reset sample one edge after the fill ends
      st_next.armed = (st_reg.phase == PEIL_RUN);
      case (st_reg.phase)
         PEIL_FILL1: st_next.phase = PEIL_FILL2;
         PEIL_FILL2: st_next.phase = PEIL_RUN;
         PEIL_RUN: st_next.phase = PEIL_RUN;
         default: st_next.phase = PEIL_FILL1;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st_reg.meta <= '0;
         st_reg.sync <= '0;
         st_reg.prev <= '0;
         st_reg.phase <= PEIL_FILL1;
         st_reg.armed <= 1'b0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign live_o = st_reg.sync;

   // Edges are ignored until prev holds a real sample, so reset gives no false event
   for (genvar i = 0; i < SRC_W; i++)
   begin : g_edge
      assign edge_o[i] = st_reg.armed &&
         (pol_i[i] ? (st_reg.sync[i] && !st_reg.prev[i]) : (!st_reg.sync[i] && st_reg.prev[i]));
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   property p_no_edge_while_filling;
      (st_reg.phase != PEIL_RUN) |-> (edge_o == '0);
   endproperty
   a_no_edge_while_filling: assert property (p_no_edge_while_filling)
      else $error("edge reported before sampling restarted");

endmodule
`default_nettype wire

// ==== sim/testbench.sv ====
// Self-checking bench for the PLL event interrupt logic
`timescale 1ns/1ps
`default_nettype none

module testbench
   import peil_pkg::*;
;
   logic clk_i;
   logic rst_i;
   peil_src_type src;
   logic cyc;
   logic stb;
   logic we;
   logic [7:0] adr;
   logic [3:0] sel;
   logic [31:0] dat;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic irq_o;
   logic [7:0] q;
   int error_cnt;
   int check_count;

   peil_top DUT
   (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .src_i(src),
      .wb_cyc_i(cyc),
      .wb_stb_i(stb),
      .wb_we_i(we),
      .wb_adr_i(adr),
      .wb_sel_i(sel),
      .wb_dat_i(dat),
      .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o),
      .irq_o(irq_o)
   );

   initial
   begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end

   task automatic print_verdict();
      $display("errors %0d checks %0d", error_cnt, check_count);
      if (error_cnt == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      check_count++;
      if (g !== e)
      begin
         error_cnt++;
         $display("[ERR] %0t got %h expected %h", $time, g, e);
      end
   endtask

   // Classic single cycle; request held until ack is sampled high
   task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'hf;
      dat <= {24'h0, d};
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (wb_ack_o !== 1'b1 && n < 20);
      q = wb_dat_o[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      if (n >= 20 && wb_ack_o !== 1'b1)
      begin
         error_cnt++;
         $display("[ERR] %0t bus answer missing", $time);
         print_verdict();
      end
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      wb(a, 1'b0, 8'h00);
      chk(q, e);
   endtask

   // Source change then enough cycles for sync, latch and irq
   task automatic put_src(input logic [7:0] v);
      @(posedge clk_i);
      src <= peil_src_type'(v);
      repeat (6) @(posedge clk_i);
   endtask

   task automatic irq_chk(input logic e);
      repeat (3) @(posedge clk_i);
      chk({7'h0, irq_o}, {7'h0, e});
   endtask

   task automatic t_reset();
      rd_chk(8'h38, 8'h00);
      rd_chk(8'h3c, 8'h00);
      rd_chk(8'h40, 8'h00);
      rd_chk(8'h44, 8'h00);
      irq_chk(1'b0);
   endtask

   task automatic t_regs();
      wb(8'h38, 1'b1, 8'ha5);
      rd_chk(8'h38, 8'ha5);
      wb(8'h3c, 1'b1, 8'h5a);
      rd_chk(8'h3c, 8'h5a);
      wb(8'h48, 1'b1, 8'hff);
      rd_chk(8'h48, 8'h00);
      wb(8'h38, 1'b1, 8'h00);
   endtask

   task automatic t_disabled();
      wb(8'h3c, 1'b1, 8'hff);
      put_src(8'h20);
      rd_chk(8'h34, 8'h20);
      rd_chk(8'h40, 8'h00);
      chk({7'h0, irq_o}, 8'h00);
      put_src(8'h00);
   endtask

   task automatic t_rise_clear();
      wb(8'h44, 1'b1, 8'h01);
      for (int i = 0; i < 8; i++)
      begin
         put_src(8'h01 << i);
         put_src(8'h00);
      end
      rd_chk(8'h40, 8'hff);
      irq_chk(1'b1);
      wb(8'h40, 1'b1, 8'h7f);
      rd_chk(8'h40, 8'h7f);
      wb(8'h40, 1'b1, 8'hbf);
      rd_chk(8'h40, 8'h3f);
      wb(8'h40, 1'b1, 8'h00);
      rd_chk(8'h40, 8'h00);
      irq_chk(1'b0);
   endtask

   task automatic t_fall_block();
      wb(8'h3c, 1'b1, 8'h00);
      put_src(8'h01);
      rd_chk(8'h40, 8'h00);
      put_src(8'h00);
      rd_chk(8'h40, 8'h01);
      irq_chk(1'b1);
      wb(8'h38, 1'b1, 8'h01);
      irq_chk(1'b0);
      wb(8'h38, 1'b1, 8'h00);
      irq_chk(1'b1);
   endtask

   task automatic t_and();
      wb(8'h44, 1'b1, 8'h03);
      irq_chk(1'b0);
      wb(8'h38, 1'b1, 8'hfe);
      irq_chk(1'b1);
      wb(8'h38, 1'b1, 8'h00);
      wb(8'h40, 1'b1, 8'h00);
      wb(8'h44, 1'b1, 8'h01);
   endtask

   task automatic t_suppress();
      wb(8'h3c, 1'b1, 8'hff);
      put_src(8'hc0);
      rd_chk(8'h34, 8'h40);
      rd_chk(8'h40, 8'h40);
      irq_chk(1'b1);
      wb(8'h44, 1'b1, 8'h00);
      irq_chk(1'b0);
      rd_chk(8'h34, 8'h40);
      put_src(8'h00);
      rd_chk(8'h40, 8'h40);
   endtask

   // Source already high through a mid-run reset must not count as a rise
   task automatic t_rereset();
      put_src(8'h02);
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      rd_chk(8'h40, 8'h00);
      rd_chk(8'h34, 8'h02);
      wb(8'h3c, 1'b1, 8'hff);
      wb(8'h44, 1'b1, 8'h01);
      irq_chk(1'b0);
      rd_chk(8'h40, 8'h00);
      put_src(8'h00);
      put_src(8'h02);
      rd_chk(8'h40, 8'h02);
   endtask

   initial
   begin
      error_cnt = 0;
      check_count = 0;
      rst_i = 1'b1;
      src = peil_src_type'(8'h00);
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 8'h00;
      sel = 4'h0;
      dat = 32'h0;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_regs();
      t_disabled();
      t_rise_clear();
      t_fall_block();
      t_and();
      t_suppress();
      t_rereset();
      print_verdict();
   end
endmodule

`default_nettype wire
